// ==== inc/sac_pkg.sv ====
package sac_pkg;

  // Sys clock rate and derived cycle counts (least times round up)
  localparam int CLK_MHZ        = 200;
  localparam int CONV_TIME_NS   = 290;
  localparam int RST_DELAY_NS   = 100;
  localparam int RDY_DELAY_NS   = 20;
  localparam int WR_DELAY_NS    = 40;
  localparam int CONV_CYC       = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_CYC        = (RST_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int RDY_CYC        = (RDY_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int WR_CYC         = (WR_DELAY_NS * CLK_MHZ + 999) / 1000;

  // Frame and result geometry
  localparam int FRAME_BITS     = 20;
  localparam int RES_W          = 18;
  localparam logic [4:0] FRAME_CNT = 5'h14;
  localparam logic signed [19:0] RES_MAX = 20'sh1ffff;
  localparam logic signed [19:0] RES_MIN = 20'she0000;
  localparam logic [17:0] RES_POS_SAT = 18'h1ffff;
  localparam logic [17:0] RES_NEG_SAT = 18'h20000;
  localparam logic [17:0] RES_RST     = 18'h00000;
  // Arbitrary fixed test pattern
  localparam logic [17:0] TEST_PATTERN = 18'h2c3a5;

  // Command prefixes
  localparam logic [3:0] CMD_RD = 4'h9;
  localparam logic [3:0] CMD_WR = 4'ha;

  // Configuration register addresses and reset values
  localparam logic [7:0] ADDR_PROTO   = 8'h00;
  localparam logic [7:0] ADDR_OUT_CTL = 8'h01;
  localparam logic [7:0] ADDR_USER0   = 8'h02;
  localparam logic [7:0] ADDR_USER1   = 8'h03;
  localparam logic [7:0] REG_RST      = 8'h00;

  // Field positions
  localparam int PR_LAUNCH = 0;
  localparam int PR_INTCLK = 1;
  localparam int OC_PATN   = 0;
  localparam int OC_PARITY_ENABLE = 3;
  localparam int OC_PLOC   = 4;

  // Partial-parity groups over D[19:2], picked by the location field
  localparam logic [3:0][17:0] PLOC_MASK = {18'h003ff, 18'h3f000, 18'h3c000, 18'h3fc00};

  typedef enum logic [1:0] {
    ST_RST = 2'b00,
    ST_ACQ = 2'b01,
    ST_CNV = 2'b11
  } sac_state_t;

  typedef struct packed {
    logic       int_out;
    logic       launch_sel;
    logic [1:0] ploc;
    logic       parity_enable;
    logic [2:0] patn;
  } sac_cfg_t;

  typedef struct packed {
    logic        fresh;
    logic [4:0]  cnt;
    logic [19:0] input_shift_register;
  } sac_rx_t;

endpackage

// ==== rtl/sac_core.sv ====
`timescale 1ns/1ps
module sac_core
  import sac_pkg::*;
(
  // System
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire logic               ce,
  // Device pins
  input  wire logic               reset_pin_n,
  input  wire logic               conversion_start,
  input  wire logic               cs_n,
  input  wire logic               sclk,
  input  wire logic               serial_in,
  output logic                    serial_out_lanes,
  output logic                    serial_out_oe_n,
  output logic                    ready_strobe,
  // Converter core
  input  wire logic signed [19:0] conv_sample,
  output logic                    conversion_status,
  output logic [17:0]             conv_result
);
  import sac_pkg::*;

  // Synchronisers (first stage read only by second)
  logic       rstp_s1_ff, rstp_s2_ff;
  logic       cs_s1_ff, cs_s2_ff, cs_s3_ff;
  logic       cv_s1_ff, cv_s2_ff, cv_s3_ff;
  logic       fr_s1_ff, fr_s2_ff, fr_s3_ff;

  sac_state_t state_ff;
  logic [9:0] wait_ff;
  logic [17:0] result_ff;
  sac_cfg_t   cfg_ff;
  logic [7:0] user0_ff, user1_ff;
  logic       rd_pend_ff;
  logic [7:0] rd_data_ff;
  logic [19:0] tx_word_ff;
  logic       frame_ff;
  logic [3:0] ret_ff;
  logic [4:0] int_ptr_ff;
  logic       int_bit_ff;
  logic       tog_ff;
  logic       rdy_ff, nxt_rdy;
  logic       oe_n_ff;

  // Link clock domain
  logic       fresh_ff;
  logic [4:0] cnt_ff;
  logic [19:0] isr_ff;
  sac_rx_t    rx_ff;
  logic [4:0] ptr_neg_ff;
  logic [4:0] lnk_ptr, lnk_idx;
  logic       lnk_bit;

  logic       pin_ok, cs_fall, cs_rise, conv_rise;
  logic       cmd_ok, is_rd, is_wr;
  logic [7:0] cmd_addr, cmd_data, rd_mux;
  logic [17:0] body;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rstp_s1_ff <= 1'b0;
      rstp_s2_ff <= 1'b0;
      cs_s1_ff   <= 1'b1;
      cs_s2_ff   <= 1'b1;
      cs_s3_ff   <= 1'b1;
      cv_s1_ff   <= 1'b0;
      cv_s2_ff   <= 1'b0;
      cv_s3_ff   <= 1'b0;
      fr_s1_ff   <= 1'b1;
      fr_s2_ff   <= 1'b1;
      fr_s3_ff   <= 1'b1;
    end else if (ce) begin
      rstp_s1_ff <= reset_pin_n;
      rstp_s2_ff <= rstp_s1_ff;
      cs_s1_ff   <= cs_n;
      cs_s2_ff   <= cs_s1_ff;
      cs_s3_ff   <= cs_s2_ff;
      cv_s1_ff   <= conversion_start;
      cv_s2_ff   <= cv_s1_ff;
      cv_s3_ff   <= cv_s2_ff;
      fr_s1_ff   <= rx_ff.fresh;
      fr_s2_ff   <= fr_s1_ff;
      fr_s3_ff   <= fr_s2_ff;
    end
  end

  assign pin_ok    = rstp_s2_ff;
  assign cs_fall   = cs_s3_ff & ~cs_s2_ff;
  assign cs_rise   = ~cs_s3_ff & cs_s2_ff;
  assign conv_rise = cv_s2_ff & ~cv_s3_ff;

  // Device state machine
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= ST_RST;
      wait_ff  <= 10'h000;
    end else if (ce) begin
      if (!pin_ok) begin
        state_ff <= ST_RST;
        wait_ff  <= 10'h000;
      end else begin
        unique case (state_ff)
          ST_RST: begin
            if (wait_ff == 10'(RST_CYC - 1)) begin
              state_ff <= ST_ACQ;
              wait_ff  <= 10'h000;
            end else begin
              wait_ff <= wait_ff + 10'h001;
            end
          end
          ST_ACQ: begin
            if (conv_rise) begin
              state_ff <= ST_CNV;
              wait_ff  <= 10'h000;
            end
          end
          ST_CNV: begin
            // Start edges simply not looked at here
            if (wait_ff == 10'(CONV_CYC - 1)) begin
              state_ff <= ST_ACQ;
              wait_ff  <= 10'h000;
            end else begin
              wait_ff <= wait_ff + 10'h001;
            end
          end
          default: begin
            state_ff <= ST_RST;
            wait_ff  <= 10'h000;
          end
        endcase
      end
    end
  end

  assign conversion_status = (state_ff != ST_CNV);

  // Result capture with saturation
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      result_ff <= RES_RST;
    end else if (ce && pin_ok && state_ff == ST_CNV && wait_ff == 10'(CONV_CYC - 1)) begin
      if (conv_sample > RES_MAX) begin
        result_ff <= RES_POS_SAT;
      end else if (conv_sample < RES_MIN) begin
        result_ff <= RES_NEG_SAT;
      end else begin
        result_ff <= conv_sample[17:0];
      end
    end
  end

  assign conv_result = result_ff;

  // Link side: capture on rising sclk; fresh-frame flag set by cs_n, cleared by the first rising sclk
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      fresh_ff <= 1'b1;   // relies on sclk idle at release
    end else begin
      fresh_ff <= 1'b0;
    end
  end

  // No reset: contents only read when fresh is clear
  always_ff @(posedge sclk) begin
    if (!cs_n) begin
      if (rx_ff.fresh) begin
        cnt_ff <= 5'h01;
        isr_ff <= {19'h00000, serial_in};
      end else begin
        if (rx_ff.cnt != FRAME_CNT) begin
          cnt_ff <= cnt_ff + 5'h01;
        end
        isr_ff <= {isr_ff[18:0], serial_in};
      end
    end
  end

  assign rx_ff   = '{fresh: fresh_ff, cnt: cnt_ff, input_shift_register: isr_ff};
  assign lnk_ptr = rx_ff.fresh ? 5'h00 : rx_ff.cnt;

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      ptr_neg_ff <= 5'h00;
    end else begin
      ptr_neg_ff <= lnk_ptr;
    end
  end

  // Launch on capture edge or the opposite edge
  // Rising launch: first rise still presents D19, so index lags the count
  assign lnk_idx = cfg_ff.launch_sel ? (rx_ff.fresh ? 5'h00 : rx_ff.cnt - 5'h01)
                                     : ptr_neg_ff;
  assign lnk_bit = (lnk_idx < FRAME_CNT) ? tx_word_ff[5'h13 - lnk_idx] : 1'b0;

  // Command decode of the held input register
  assign cmd_addr = rx_ff.input_shift_register[15:8];
  assign cmd_data = rx_ff.input_shift_register[7:0];
  // Third stage: flag as it stood before cs_n rose, not its async set
  assign cmd_ok   = !fr_s3_ff && (rx_ff.cnt == FRAME_CNT);
  assign is_rd    = cmd_ok && rx_ff.input_shift_register[19:16] == CMD_RD && cmd_data == 8'h00;
  assign is_wr    = cmd_ok && rx_ff.input_shift_register[19:16] == CMD_WR;

  always_comb begin
    unique case (cmd_addr)
      ADDR_PROTO:   rd_mux = {6'h00, cfg_ff.int_out, cfg_ff.launch_sel};
      ADDR_OUT_CTL: rd_mux = {1'b0, cfg_ff.ploc, cfg_ff.parity_enable, cfg_ff.patn};
      ADDR_USER0:   rd_mux = user0_ff;
      ADDR_USER1:   rd_mux = user1_ff;
      default:      rd_mux = 8'h00;
    endcase
  end

  // Configuration registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg_ff   <= sac_cfg_t'(REG_RST);
      user0_ff <= REG_RST;
      user1_ff <= REG_RST;
    end else if (ce) begin
      if (!pin_ok) begin
        cfg_ff   <= sac_cfg_t'(REG_RST);
        user0_ff <= REG_RST;
        user1_ff <= REG_RST;
      end else if (cs_rise && is_wr) begin
        unique case (cmd_addr)
          ADDR_PROTO: begin
            cfg_ff.launch_sel <= cmd_data[PR_LAUNCH];
            cfg_ff.int_out    <= cmd_data[PR_INTCLK];
          end
          ADDR_OUT_CTL: begin
            cfg_ff.patn   <= cmd_data[OC_PATN +: 3];
            cfg_ff.parity_enable <= cmd_data[OC_PARITY_ENABLE];
            cfg_ff.ploc   <= cmd_data[OC_PLOC +: 2];
          end
          ADDR_USER0: user0_ff <= cmd_data;
          ADDR_USER1: user1_ff <= cmd_data;
          default: ;
        endcase
      end
    end
  end

  // Read result waits for the next frame
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_pend_ff <= 1'b0;
      rd_data_ff <= 8'h00;
    end else if (ce) begin
      if (!pin_ok) begin
        rd_pend_ff <= 1'b0;
      end else if (cs_rise) begin
        rd_pend_ff <= is_rd;
        rd_data_ff <= rd_mux;
      end else if (cs_fall) begin
        rd_pend_ff <= 1'b0;
      end
    end
  end

  // Output word, frozen for the whole frame so the link side can index it
  assign body = cfg_ff.patn[2] ? TEST_PATTERN : result_ff;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_word_ff <= 20'h00000;
    end else if (ce && pin_ok && cs_fall) begin
      if (rd_pend_ff) begin
        tx_word_ff <= {rd_data_ff, 12'h000};
      end else if (cfg_ff.parity_enable) begin
        tx_word_ff <= {body, ^body, ^(body & PLOC_MASK[cfg_ff.ploc])};
      end else begin
        tx_word_ff <= {body, 2'b00};
      end
    end
  end

  // Frame tracking and strobe return delay
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      frame_ff <= 1'b0;
      ret_ff   <= 4'h0;
    end else if (ce) begin
      if (!pin_ok) begin
        frame_ff <= 1'b0;
        ret_ff   <= 4'h0;
      end else if (cs_fall) begin
        frame_ff <= 1'b1;
        ret_ff   <= 4'h0;
      end else if (cs_rise) begin
        frame_ff <= 1'b0;
        ret_ff   <= is_wr ? 4'(WR_CYC) : 4'(RDY_CYC);
      end else if (ret_ff != 4'h0) begin
        ret_ff <= ret_ff - 4'h1;
      end
    end
  end

  // Internal-clock read-out: one bit per sys_clk, strobe toggles per bit
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      int_ptr_ff <= 5'h00;
      int_bit_ff <= 1'b0;
      tog_ff     <= 1'b0;
    end else if (ce) begin
      if (!frame_ff || !cfg_ff.int_out) begin
        int_ptr_ff <= 5'h00;
        int_bit_ff <= tx_word_ff[19];
        tog_ff     <= 1'b0;
      end else if (int_ptr_ff < FRAME_CNT) begin
        int_bit_ff <= tx_word_ff[5'h13 - int_ptr_ff];
        int_ptr_ff <= int_ptr_ff + 5'h01;
        tog_ff     <= ~tog_ff;
      end else begin
        int_bit_ff <= 1'b0;
        tog_ff     <= 1'b0;
      end
    end
  end

  always_comb begin
    if (state_ff == ST_RST || !pin_ok) begin
      nxt_rdy = 1'b0;
    end else if (frame_ff || cs_fall) begin
      nxt_rdy = cfg_ff.int_out & tog_ff;
    end else if (cs_rise || ret_ff != 4'h0) begin
      nxt_rdy = 1'b0;
    end else begin
      nxt_rdy = conversion_status;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdy_ff  <= 1'b0;
      oe_n_ff <= 1'b1;
    end else if (ce) begin
      rdy_ff  <= nxt_rdy;
      oe_n_ff <= !(pin_ok && state_ff != ST_RST && !cs_s2_ff);
    end
  end

  assign ready_strobe     = rdy_ff;
  assign serial_out_oe_n  = oe_n_ff;
  assign serial_out_lanes = cfg_ff.int_out ? int_bit_ff : lnk_bit;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  rst_strobe_a: assert property ((state_ff == ST_RST) |=> !ready_strobe)
    else $error("strobe high after reset state");
  rst_tristate_a: assert property ((ce && !pin_ok) |=> serial_out_oe_n)
    else $error("outputs driven during reset");
  conv_start_a: assert property (
    (ce && pin_ok && state_ff == ST_ACQ && conv_rise) |=> (state_ff == ST_CNV))
    else $error("start edge did not convert");
  conv_ignore_a: assert property (
    (ce && pin_ok && state_ff == ST_CNV && wait_ff < 10'(CONV_CYC - 1))
      |=> (state_ff == ST_CNV) && $stable(result_ff))
    else $error("conversion cut short");
  acq_after_a: assert property (
    (ce && pin_ok && state_ff == ST_CNV && wait_ff == 10'(CONV_CYC - 1))
      |=> (state_ff == ST_ACQ))
    else $error("no acquire after conversion");
  rst_release_a: assert property (
    (ce && pin_ok && state_ff == ST_RST && wait_ff == 10'(RST_CYC - 1)) |=> (state_ff == ST_ACQ))
    else $error("reset release not acquiring");
  strobe_follow_a: assert property (
    (ce && pin_ok && state_ff != ST_RST && !frame_ff && !cs_fall && !cs_rise && ret_ff == 4'h0)
      |=> (ready_strobe == $past(conversion_status)))
    else $error("strobe not following status");
  frame_low_a: assert property (
    (ce && pin_ok && cs_fall && !cfg_ff.int_out) |=> !ready_strobe[*2])
    else $error("strobe high at frame start");
  end_delay_a: assert property (
    (ce && pin_ok && cs_rise) |=> !ready_strobe ##1 !ready_strobe)
    else $error("strobe returned too early");
  short_nop_a: assert property (
    (ce && pin_ok && cs_rise && (fr_s3_ff || rx_ff.cnt < FRAME_CNT)) |=> $stable(cfg_ff))
    else $error("short frame changed config");
  sat_pos_a: assert property (
    (ce && pin_ok && state_ff == ST_CNV && wait_ff == 10'(CONV_CYC - 1) && conv_sample > RES_MAX)
      |=> (conv_result == RES_POS_SAT))
    else $error("positive limit not saturated");
  par_off_a: assert property (
    (ce && pin_ok && cs_fall && !rd_pend_ff && !cfg_ff.parity_enable) |=> (tx_word_ff[1:0] == 2'b00))
    else $error("parity bits nonzero");
  rd_word_a: assert property (
    (ce && pin_ok && cs_fall && rd_pend_ff) |=> (tx_word_ff[11:0] == 12'h000))
    else $error("read word low bits nonzero");

  conv_done_c: cover property (state_ff == ST_CNV ##1 state_ff == ST_ACQ);
  write_cmd_c: cover property (cs_rise && is_wr);
  read_cmd_c:  cover property (cs_rise && is_rd ##[1:300] cs_fall);
  short_c:     cover property (cs_rise && !fr_s3_ff && rx_ff.cnt < FRAME_CNT);

endmodule // sac_core

// ==== verification/sac_host.sv ====
`timescale 1ns/1ps
module sac_host (
  // Link pins
  output logic      cs_n,
  output logic      sclk,
  output logic      serial_in,
  // Device outputs
  input  wire logic lane,
  input  wire logic oe_n,
  input  wire logic rdy
);
  logic ls;
  wire  lane_w;

  // Released lane shows the inverse, so a sample taken then fails
  assign lane_w = oe_n ? ~lane : lane;

  initial begin
    cs_n      = 1'b1;
    sclk      = 1'b0;
    serial_in = 1'b0;
    ls        = 1'b0;
  end

  // Clock stands low outside frames; extra leading bits precede the command
  task automatic frame(input int n, input logic [19:0] cmd,
                       output logic [19:0] got, output logic [1:0] mid);
    logic [31:0] v;
    v   = {12'h5a5, cmd};
    got = 20'h00000;
    cs_n = 1'b0;
    #25;
    mid = {oe_n, rdy};
    for (int k = n - 1; k >= 0; k--) begin
      int j;
      j = n - 1 - k;
      serial_in = v[k];
      #3;
      if (!ls && j < 20) got[19 - j] = lane_w;
      sclk = 1'b1;
      #3;
      if (ls && j < 20) got[19 - j] = lane_w;
      sclk = 1'b0;
    end
    #3;
    cs_n      = 1'b1;
    serial_in = ~serial_in;
  endtask
endmodule // sac_host

// ==== verification/test_sac_core.sv ====
`timescale 1ns/1ps
module test_sac_core;
  import sac_pkg::*;
  logic               sys_clk;
  logic               reset;
  logic               reset_pin_n;
  logic               conversion_start;
  logic signed [19:0] conv_sample;
  logic               cs_n;
  logic               sclk;
  logic               serial_in;
  logic               serial_out_lanes;
  logic               serial_out_oe_n;
  logic               ready_strobe;
  logic               conversion_status;
  logic [17:0]        conv_result;
  logic [31:0]        rs;
  logic [31:0]        v;
  logic [7:0]         oc;
  logic [17:0]        res_exp;
  logic [19:0]        got;
  logic [1:0]         mid;
  logic signed [19:0] corner [6];
  int                 num_errors;
  int                 n_tests;

  sac_core dut (
    .sys_clk          (sys_clk),
    .reset            (reset),
    .ce               (1'b1),
    .reset_pin_n      (reset_pin_n),
    .conversion_start (conversion_start),
    .cs_n             (cs_n),
    .sclk             (sclk),
    .serial_in        (serial_in),
    .serial_out_lanes (serial_out_lanes),
    .serial_out_oe_n  (serial_out_oe_n),
    .ready_strobe     (ready_strobe),
    .conv_sample      (conv_sample),
    .conversion_status(conversion_status),
    .conv_result      (conv_result)
  );

  sac_host host (
    .cs_n     (cs_n),
    .sclk     (sclk),
    .serial_in(serial_in),
    .lane     (serial_out_lanes),
    .oe_n     (serial_out_oe_n),
    .rdy      (ready_strobe)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  function automatic logic [17:0] sat(input logic signed [19:0] s);
    if (s > 20'sh1ffff) return 18'h1ffff;
    if (s < 20'she0000) return 18'h20000;
    return s[17:0];
  endfunction

  function automatic logic [19:0] word();
    logic [17:0] d;
    logic [17:0] m;
    d = oc[2] ? TEST_PATTERN : res_exp;
    case (oc[5:4])
      2'h0: m = 18'h3fc00;
      2'h1: m = 18'h3c000;
      2'h2: m = 18'h3f000;
      default: m = 18'h003ff;
    endcase
    return {d, oc[3] & ^d, oc[3] & ^(d & m)};
  endfunction

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Bounded wait; a hang is counted and ends the run
  task automatic wait_rdy(input logic lvl, output int n);
    n = 0;
    while (ready_strobe !== lvl) begin
      step(1);
      n++;
      if (n > 300) begin
        check({19'h0, ready_strobe}, {19'h0, lvl});
        finish_test();
      end
    end
  endtask

  task automatic do_frame(input int n, input logic [19:0] cmd);
    int w;
    host.frame(n, cmd, got, mid);
    check({18'h0, mid}, 20'h00000);
    step(1);
    wait_rdy(1'b1, w);
    check({19'h0, serial_out_oe_n}, 20'h00001);
  endtask

  task automatic read_word();
    do_frame(20, 20'h00000);
    check(got, word());
  endtask

  // Internal clock: cs_n seen after two edges, word latched on the third
  task automatic int_read();
    logic [19:0] tg;
    int          w;
    host.cs_n = 1'b0;
    step(4);
    for (int k = 19; k >= 0; k--) begin
      got[k] = serial_out_lanes;
      tg[k]  = ready_strobe;
      step(1);
    end
    host.cs_n = 1'b1;
    wait_rdy(1'b1, w);
    check(got, word());
    check(tg, 20'h55555);
    check({19'h0, serial_out_oe_n}, 20'h00001);
  endtask

  task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
    do_frame(20, {4'h9, a, 8'h00});
    do_frame(20, 20'h00000);
    check(got, {exp, 12'h000});
  endtask

  task automatic convert(input logic signed [19:0] s);
    int n;
    conv_sample = s;
    conversion_start = 1'b1;
    wait_rdy(1'b0, n);
    n = 0;
    while (ready_strobe === 1'b0 && n < 300) begin
      if (n == 5) conversion_start = 1'b0;
      if (n == 9) conversion_start = 1'b1;
      n++;
      step(1);
    end
    conversion_start = 1'b0;
    check(20'(n), 20'(CONV_CYC));
    check({19'h0, conversion_status}, 20'h00001);
    res_exp = sat(s);
    check({2'h0, conv_result}, {2'h0, res_exp});
    step(3);
  endtask

  task automatic pin_reset();
    int n;
    reset_pin_n = 1'b0;
    step(10);
    check({18'h0, ready_strobe, serial_out_oe_n}, 20'h00001);
    reset_pin_n = 1'b1;
    wait_rdy(1'b1, n);
    check(20'(n >= RST_CYC && n <= RST_CYC + 5), 20'h00001);
    oc = 8'h00;
  endtask

  initial begin
    rs = 32'hee7d4317;
    num_errors = 0;
    n_tests = 0;
    reset = 1'b1;
    reset_pin_n = 1'b0;
    conversion_start = 1'b0;
    conv_sample = 20'sh00000;
    oc = 8'h00;
    res_exp = 18'h00000;
    corner = '{20'sh1ffff, 20'sh20000, 20'she0000, 20'shdffff, 20'shfffff, 20'sh00000};
    step(20);
    reset = 1'b0;
    pin_reset();
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      v = xs();
      convert(i < 6 ? corner[i] : v[19:0]);
      read_word();
    end
    $display("test convert done");
    for (int i = 0; i < 4; i++) begin
      v = xs();
      oc = {2'h0, i[1:0], 1'b1, v[2:0]};
      do_frame(20, {4'ha, 8'h01, oc});
      convert(v[31:12]);
      read_word();
    end
    $display("test parity done");
    reg_check(8'h01, oc);
    read_word();
    do_frame(10, {4'ha, 8'h01, 8'h3c});
    reg_check(8'h01, oc);
    oc = 8'h08;
    do_frame(25, {4'ha, 8'h01, oc});
    reg_check(8'h01, oc);
    do_frame(20, 20'hfffff);
    do_frame(20, 20'h30a55);
    reg_check(8'h01, oc);
    $display("test command done");
    do_frame(20, {4'ha, 8'h00, 8'h01});
    host.ls = 1'b1;
    read_word();
    do_frame(20, {4'ha, 8'h00, 8'h00});
    host.ls = 1'b0;
    read_word();
    $display("test launch done");
    do_frame(20, {4'ha, 8'h00, 8'h02});
    int_read();
    $display("test internal clock done");
    pin_reset();
    reg_check(8'h01, 8'h00);
    $display("test pin reset done");
    finish_test();
  end
endmodule // test_sac_core
